// ---- adr_checker.sv ----
// assertions on the handshake sequencer ports
// assumes bench-sized windows handed in by the bind
`timescale 1ns/1ps
module adr_checker
	import adr_pkg::*;
#(
	parameter int unsigned ANN_CYC   = SLV_ANNOUNCE_CYC,
	parameter int unsigned CHOLD_CYC = CMD_HOLD_CYC
)
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic is_slave,
	input  wire logic reset_n_in,
	input  wire logic dasp_n_in,
	input  wire logic pdiag_n_in,
	input  wire logic soft_reset,
	input  wire logic diag_cmd,
	input  wire logic host_cmd,
	input  wire logic dasp_n_oe,
	input  wire logic pdiag_n_oe,
	input  wire logic bsy,
	input  wire logic seq_done,
	input  wire logic slave_present,
	input  wire logic slave_pass
);
	localparam int ANN_LIM  = ANN_CYC + 6;
	localparam int DIAG_LIM = CHOLD_CYC + 10;
	logic [3:0] dlow_r;
	logic [3:0] plow_r;
	logic       dseen_r;
	logic       cmd_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ********************
	// helpers: age of last low level, presence seen, event kind
	// ********************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dlow_r  <= 4'hf;
			plow_r  <= 4'hf;
			dseen_r <= 1'b0;
			cmd_r   <= 1'b0;
		end
		else
		begin
			dlow_r  <= !dasp_n_in ? 4'h0 : (dlow_r == 4'hf ? dlow_r : dlow_r + 4'h1);
			plow_r  <= !pdiag_n_in ? 4'h0 : (plow_r == 4'hf ? plow_r : plow_r + 4'h1);
			dseen_r <= $rose(reset_n_in) ? 1'b0 : (dseen_r | !dasp_n_in);
			cmd_r   <= (soft_reset | diag_cmd) ? 1'b1 : (!reset_n_in ? 1'b0 : cmd_r);
		end
	end
	// ********************
	// properties
	// ********************
	sequence s_cable_rel;
		$rose(reset_n_in);
	endsequence
	sequence s_mst_diag;
		!is_slave && diag_cmd;
	endsequence
	property p_bsy_set;
		s_cable_rel |-> ##[1:6] bsy;
	endproperty
	property p_present;
		$rose(slave_present) |-> !is_slave && dlow_r <= 4'h8;
	endproperty
	property p_pass;
		$rose(slave_pass) |-> slave_present && plow_r <= 4'h8;
	endproperty
	property p_absent;
		$rose(seq_done) && !is_slave && !dseen_r |-> !slave_present;
	endproperty
	property p_keep;
		!is_slave && (soft_reset || diag_cmd) |=> $stable(slave_present) [*8];
	endproperty
	property p_diag_wait;
		s_mst_diag |-> ##[1:DIAG_LIM] (seq_done && !bsy);
	endproperty
	property p_announce;
		s_cable_rel ##0 is_slave |-> ##[1:ANN_LIM] (!dasp_n_oe && pdiag_n_oe);
	endproperty
	property p_soft_on;
		is_slave && soft_reset |-> ##[1:3] (!dasp_n_oe && pdiag_n_oe);
	endproperty
	property p_soft_off;
		is_slave && cmd_r && $fell(pdiag_n_oe) |-> dasp_n_oe;
	endproperty
	property p_host_rel;
		is_slave && host_cmd && !cmd_r |-> ##[1:3] dasp_n_oe;
	endproperty
	a_bsy_set: assert property (p_bsy_set) else $error("busy late after cable reset");
	a_present: assert property (p_present) else $error("presence without line");
	a_pass: assert property (p_pass) else $error("pass without diag line");
	a_absent: assert property (p_absent) else $error("presence with quiet line");
	a_keep: assert property (p_keep) else $error("presence changed on event");
	a_diag_wait: assert property (p_diag_wait) else $error("diag wait too long");
	a_announce: assert property (p_announce) else $error("slave announce late");
	a_soft_on: assert property (p_soft_on) else $error("slave lines wrong after soft");
	a_soft_off: assert property (p_soft_off) else $error("present line not released");
	a_host_rel: assert property (p_host_rel) else $error("present line held after cmd");
endmodule

bind adr_seq adr_checker #(.ANN_CYC(ANN_CYC), .CHOLD_CYC(CHOLD_CYC)) u_chk (.core_clk(core_clk), .rst(rst),
	.is_slave(is_slave), .reset_n_in(reset_n_in), .dasp_n_in(dasp_n_in), .pdiag_n_in(pdiag_n_in),
	.soft_reset(soft_reset), .diag_cmd(diag_cmd), .host_cmd(host_cmd), .dasp_n_oe(dasp_n_oe),
	.pdiag_n_oe(pdiag_n_oe), .bsy(bsy), .seq_done(seq_done), .slave_present(slave_present),
	.slave_pass(slave_pass));

// ---- adr_peer.sv ----
// far drive model: a slave drive sharing the cable
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/1ps
module adr_peer
(
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic       hard,
	input  wire logic       here,
	input  wire logic       ok,
	input  wire logic [7:0] dly,
	output logic            dasp_n_oe,
	output logic            pdiag_n_oe
);
	int   t   = 0;
	logic act = 1'b0;
	initial
	begin
		dasp_n_oe  = 1'b1;
		pdiag_n_oe = 1'b1;
	end
	// ********************
	// handshake timeline, restarted by each event
	// ********************
	always @(posedge core_clk)
	begin
		t <= go ? 0 : t + 1;
		if (go)
		begin
			act        <= here;
			pdiag_n_oe <= 1'b1;
			dasp_n_oe  <= !(here && !hard);
		end
		else if (act)
		begin
			if (hard && t == dly)
				dasp_n_oe <= 1'b0;
			if (ok && t == 2 * dly)
			begin
				pdiag_n_oe <= 1'b0;
				if (!hard)
					dasp_n_oe <= 1'b1;
			end
			if (t == 3 * dly)
			begin
				pdiag_n_oe <= 1'b1;
				dasp_n_oe  <= 1'b1;
				act        <= 1'b0;
			end
		end
	end
endmodule

// ---- adr_pkg.sv ----
// package for the dual-drive reset and diagnostic handshake
// assumes a single 10 MHz core clock and synchronous active-high reset
package adr_pkg;

	// ********************************************************
	// clock and timing
	// ********************************************************
	localparam int unsigned CLK_HZ           = 10000000;
	localparam int unsigned CLK_PERIOD_NS    = 100;
	localparam int unsigned DET_WIN_MS       = 450;
	localparam int unsigned SLV_ANNOUNCE_MS  = 400;
	localparam int unsigned PD_NEG_MS        = 1;
	localparam int unsigned RST_DIAG_S       = 30;
	localparam int unsigned RST_HOLD_S       = 31;
	localparam int unsigned CMD_DIAG_S       = 5;
	localparam int unsigned CMD_HOLD_S       = 6;
	localparam int unsigned BSY_SET_NS       = 400;
	localparam int unsigned RST_PULSE_US     = 25;

	// cycle counts: least times round up, longest round down
	localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
	localparam int unsigned DET_WIN_CYC      = DET_WIN_MS * CYC_PER_MS;
	localparam int unsigned SLV_ANNOUNCE_CYC = SLV_ANNOUNCE_MS * CYC_PER_MS;
	localparam int unsigned PD_NEG_CYC       = PD_NEG_MS * CYC_PER_MS;
	localparam int unsigned RST_DIAG_CYC     = RST_DIAG_S * CLK_HZ;
	localparam int unsigned RST_HOLD_CYC     = RST_HOLD_S * CLK_HZ;
	localparam int unsigned CMD_DIAG_CYC     = CMD_DIAG_S * CLK_HZ;
	localparam int unsigned CMD_HOLD_CYC     = CMD_HOLD_S * CLK_HZ;
	localparam int unsigned BSY_SET_CYC      = (BSY_SET_NS / CLK_PERIOD_NS) < 1 ? 1 : BSY_SET_NS / CLK_PERIOD_NS;
	localparam int unsigned RST_PULSE_CYC    = (RST_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned TMR_W            = 32;

	// ********************************************************
	// sequencer states
	// ********************************************************
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_M_DET   = 3'b001,
		ST_M_WAIT  = 3'b010,
		ST_S_ANN   = 3'b011,
		ST_S_DIAG  = 3'b100,
		ST_S_HOLD  = 3'b101
	} adr_state_t;

	// event kinds that open a window
	typedef enum logic [1:0] {
		EV_HARD = 2'b00,
		EV_SOFT = 2'b01,
		EV_DIAG = 2'b10
	} adr_event_t;

endpackage

// ---- adr_seq.sv ----
// reset and diagnostic handshake sequencer for a drive on a shared cable
// assumes core_clk at 10 MHz; dasp/pdiag are open-drain, pins resolved outside
`timescale 1ns/1ps

module adr_seq
	import adr_pkg::*;
#(
	parameter int unsigned DET_CYC      = DET_WIN_CYC,
	parameter int unsigned ANN_CYC      = SLV_ANNOUNCE_CYC,
	parameter int unsigned NEG_CYC      = PD_NEG_CYC,
	parameter int unsigned RDIAG_CYC    = RST_DIAG_CYC,
	parameter int unsigned RHOLD_CYC    = RST_HOLD_CYC,
	parameter int unsigned CDIAG_CYC    = CMD_DIAG_CYC,
	parameter int unsigned CHOLD_CYC    = CMD_HOLD_CYC,
	parameter int unsigned RPULSE_CYC   = RST_PULSE_CYC
)
(
	input  wire logic  core_clk,
	input  wire logic  rst,
	input  wire logic  is_slave,
	input  wire logic  reset_n_in,
	input  wire logic  dasp_n_in,
	input  wire logic  pdiag_n_in,
	input  wire logic  soft_reset,
	input  wire logic  diag_cmd,
	input  wire logic  host_cmd,
	input  wire logic  self_pass,
	input  wire logic  self_done,
	output logic       dasp_n_out,
	output logic       dasp_n_oe,
	output logic       pdiag_n_out,
	output logic       pdiag_n_oe,
	output logic       bsy,
	output logic       seq_done,
	output logic       slave_present,
	output logic       slave_pass
);

	typedef struct packed {
		adr_state_t       state;
		adr_event_t       ev;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] rst_len;
		logic             rst_seen;
		logic             dasp_drv;
		logic             pdiag_drv;
		logic             bsy;
		logic             done;
		logic             present;
		logic             pass;
		logic             rel_once;
	} adr_seq_st_t;

	adr_seq_st_t st_r;
	adr_seq_st_t st_nxt;
	adr_sync_if  lines ();

	// pin synchroniser
	adr_sync u_sync (
		.core_clk   (core_clk),
		.rst        (rst),
		.dasp_n_in  (dasp_n_in),
		.pdiag_n_in (pdiag_n_in),
		.reset_n_in (reset_n_in),
		.lines      (lines)
	);

	// pass window limit for the slave, by event kind
	function automatic logic [TMR_W-1:0] diag_lim(input adr_event_t e);
		diag_lim = (e == EV_DIAG) ? TMR_W'(CDIAG_CYC) : TMR_W'(RDIAG_CYC);
	endfunction

	// hold window limit, by event kind
	function automatic logic [TMR_W-1:0] hold_lim(input adr_event_t e);
		hold_lim = (e == EV_DIAG) ? TMR_W'(CHOLD_CYC) : TMR_W'(RHOLD_CYC);
	endfunction

	logic hard_evt;
	logic [TMR_W-1:0] tmr_inc;

	// hardware reset accepted only after a long enough pulse releases
	assign hard_evt = st_r.rst_seen && !lines.rst_act && (st_r.rst_len >= TMR_W'(RPULSE_CYC));
	assign tmr_inc  = st_r.tmr + TMR_W'(1);

	// ********************************************************
	// sequencer next state
	// ********************************************************
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.tmr = tmr_inc;
		// measure the reset pulse
		if (lines.rst_act)
		begin
			st_nxt.rst_seen = 1'b1;
			st_nxt.rst_len  = (st_r.rst_len == '1) ? st_r.rst_len : st_r.rst_len + TMR_W'(1);
		end
		else
		begin
			st_nxt.rst_seen = 1'b0;
			st_nxt.rst_len  = '0;
		end
		case (st_r.state)
			ST_IDLE:
			begin
				st_nxt.tmr = st_r.tmr;
			end
			ST_M_DET:
			begin
				if (lines.dasp_act)
				begin
					st_nxt.present = 1'b1;
					st_nxt.state   = ST_M_WAIT;
					st_nxt.tmr     = '0;
				end
				else if (st_r.tmr >= TMR_W'(DET_CYC - 1))
				begin
					st_nxt.present = 1'b0;
					st_nxt.state   = ST_IDLE;
					st_nxt.done    = 1'b1;
					st_nxt.bsy     = 1'b0;
				end
			end
			ST_M_WAIT:
			begin
				// dasp is ignored here; pdiag is blanked for one release window
				// so a level still held from the last event is not taken as a pass
				if (lines.pdiag_act && st_r.tmr >= TMR_W'(NEG_CYC))
				begin
					st_nxt.pass  = 1'b1;
					st_nxt.state = ST_IDLE;
					st_nxt.done  = 1'b1;
					st_nxt.bsy   = 1'b0;
				end
				else if (st_r.tmr >= hold_lim(st_r.ev) - TMR_W'(1))
				begin
					st_nxt.pass  = 1'b0;
					st_nxt.state = ST_IDLE;
					st_nxt.done  = 1'b1;
					st_nxt.bsy   = 1'b0;
				end
			end
			ST_S_ANN:
			begin
				// announce presence well within its limit, then diag
				if (st_r.tmr >= TMR_W'(NEG_CYC - 1) || st_r.tmr >= TMR_W'(ANN_CYC - 1))
				begin
					st_nxt.state = ST_S_DIAG;
				end
			end
			ST_S_DIAG:
			begin
				if (self_done && self_pass && st_r.tmr < diag_lim(st_r.ev))
				begin
					st_nxt.pdiag_drv = 1'b1;
					st_nxt.state     = ST_S_HOLD;
					st_nxt.bsy       = 1'b0;
					if (st_r.ev != EV_HARD)
						st_nxt.dasp_drv = 1'b0;
				end
				else if (st_r.tmr >= diag_lim(st_r.ev) - TMR_W'(1) || (self_done && !self_pass))
				begin
					st_nxt.state = ST_S_HOLD; // failed: diag line stays off
					st_nxt.bsy   = 1'b0;
					st_nxt.done  = 1'b1;
				end
			end
			ST_S_HOLD:
			begin
				if (st_r.tmr >= hold_lim(st_r.ev) - TMR_W'(1))
				begin
					st_nxt.pdiag_drv = 1'b0;
					st_nxt.dasp_drv  = 1'b0;
					st_nxt.state     = ST_IDLE;
					st_nxt.done      = 1'b1;
				end
			end
			default:
			begin
				st_nxt.state = ST_IDLE;
			end
		endcase
		// first edge after power-on reset opens the power-on windows
		if (st_r.ev == EV_HARD && st_r.state == ST_IDLE && !st_r.done && st_r.bsy)
		begin
			st_nxt.tmr      = '0;
			st_nxt.state    = is_slave ? ST_S_ANN : ST_M_DET;
			st_nxt.dasp_drv = is_slave;
		end
		// first host command after a power-on or hardware reset drops the slave-present line once
		if (is_slave && host_cmd && st_r.ev == EV_HARD && !st_r.rel_once)
		begin
			st_nxt.dasp_drv = 1'b0;
			st_nxt.rel_once = 1'b1;
		end
		// window-opening events, restart the counter
		if (hard_evt || soft_reset || diag_cmd)
		begin
			st_nxt.tmr       = '0;
			st_nxt.bsy       = 1'b1;
			st_nxt.done      = 1'b0;
			st_nxt.pdiag_drv = 1'b0;
			st_nxt.ev        = hard_evt ? EV_HARD : (soft_reset ? EV_SOFT : EV_DIAG);
			st_nxt.rel_once  = 1'b0;
			if (is_slave)
			begin
				st_nxt.state    = ST_S_ANN;
				st_nxt.dasp_drv = 1'b1;
			end
			else if (hard_evt)
			begin
				st_nxt.state   = ST_M_DET;
				st_nxt.present = 1'b0;
				st_nxt.pass    = 1'b0;
			end
			else if (st_r.present)
			begin
				st_nxt.state = ST_M_WAIT;
				st_nxt.pass  = 1'b0;
			end
			else
			begin
				st_nxt.state = ST_IDLE;
				st_nxt.done  = 1'b1;
				st_nxt.bsy   = 1'b0;
			end
		end
	end

	// ********************************************************
	// state register, power-on acts like a hardware reset
	// ********************************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r       <= '0;
			st_r.state <= ST_IDLE;
			st_r.ev    <= EV_HARD;
			st_r.bsy   <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// open-drain outputs: enable low means driving low (asserted)
	assign dasp_n_out    = 1'b0;
	assign dasp_n_oe     = ~st_r.dasp_drv;
	assign pdiag_n_out   = 1'b0;
	assign pdiag_n_oe    = ~st_r.pdiag_drv;
	assign bsy           = st_r.bsy;
	assign seq_done      = st_r.done;
	assign slave_present = st_r.present;
	assign slave_pass    = st_r.pass;

endmodule

// ---- adr_sync.sv ----
// three-stage pin synchroniser with agreement filter
// assumes pins are active low and asynchronous to core_clk
`timescale 1ns/1ps
module adr_sync
	import adr_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst,
	input  wire logic  dasp_n_in,
	input  wire logic  pdiag_n_in,
	input  wire logic  reset_n_in,
	adr_sync_if.src    lines
);

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] lvl;
	} adr_sync_st_t;

	adr_sync_st_t st_r;
	adr_sync_st_t st_nxt;

	// ********************************************************
	// shift and accept a level once stages two and three agree
	// ********************************************************
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.s1  = {~reset_n_in, ~pdiag_n_in, ~dasp_n_in};
		st_nxt.s2  = st_r.s1;
		st_nxt.s3  = st_r.s2;
		for (int i = 0; i < 3; i++)
		begin
			if (st_r.s2[i] == st_r.s3[i])
				st_nxt.lvl[i] = st_r.s3[i];
		end
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign lines.dasp_act  = st_r.lvl[0];
	assign lines.pdiag_act = st_r.lvl[1];
	assign lines.rst_act   = st_r.lvl[2];

endmodule

// ---- adr_sync_if.sv ----
// interface carrying the filtered line levels from the synchroniser
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface adr_sync_if;
	logic dasp_act;     // slave-present line seen asserted
	logic pdiag_act;    // diag-pass line seen asserted
	logic rst_act;      // hardware reset line seen asserted
	modport src (output dasp_act, output pdiag_act, output rst_act);
	modport dst (input dasp_act, input pdiag_act, input rst_act);
endinterface

// ---- ata_dual_drive_reset_diag_handshake_bench.sv ----
// self-checking bench for the handshake sequencer
// assumes adr_peer as far drive and the bound checker
`timescale 1ns/1ps
module ata_dual_drive_reset_diag_handshake_bench;
	import adr_pkg::*;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic       is_slave = 1'b0;
	logic       reset_n_in = 1'b1;
	logic       soft_reset = 1'b0;
	logic       diag_cmd = 1'b0;
	logic       host_cmd = 1'b0;
	logic       self_pass = 1'b0;
	logic       self_done = 1'b0;
	logic       go = 1'b0;
	logic       hard = 1'b0;
	logic       here = 1'b0;
	logic       ok = 1'b0;
	logic [7:0] dly = 8'h05;
	logic       dasp_n_oe, pdiag_n_oe, p_dasp_n_oe, p_pdiag_n_oe;
	logic       bsy, seq_done, slave_present, slave_pass;
	wire logic  dasp_w = dasp_n_oe & p_dasp_n_oe;
	wire logic  pdiag_w = pdiag_n_oe & p_pdiag_n_oe;
	int         fail_count = 0;
	int         checks = 0;
	int         cyc = 0;
	int         seed;
	bit         m_present = 1'b0;
	// ********************
	// design, far drive, clock, timeout
	// ********************
	adr_seq #(.DET_CYC(40), .ANN_CYC(30), .NEG_CYC(5), .RHOLD_CYC(300),
		.CHOLD_CYC(60)) u_dut (.core_clk(core_clk), .rst(rst), .is_slave(is_slave), .reset_n_in(reset_n_in),
		.dasp_n_in(dasp_w), .pdiag_n_in(pdiag_w), .soft_reset(soft_reset), .diag_cmd(diag_cmd),
		.host_cmd(host_cmd), .self_pass(self_pass), .self_done(self_done), .dasp_n_out(),
		.dasp_n_oe(dasp_n_oe), .pdiag_n_out(), .pdiag_n_oe(pdiag_n_oe), .bsy(bsy), .seq_done(seq_done),
		.slave_present(slave_present), .slave_pass(slave_pass));
	adr_peer u_peer (.core_clk(core_clk), .go(go), .hard(hard), .here(here), .ok(ok), .dly(dly),
		.dasp_n_oe(p_dasp_n_oe), .pdiag_n_oe(p_pdiag_n_oe));
	initial
		forever #50 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end
	// ********************
	// tasks
	// ********************
	task automatic check(input string nm, input logic v, input logic e);
		checks++;
		if (v !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, v);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// master side: kind 0 power-on, 1 cable reset, 2 soft reset, 3 diag command
	task automatic mcase(input int kind, input bit hp, input bit okp);
		int n;
		@(negedge core_clk);
		{here, ok, hard} = {hp, okp, kind < 2};
		dly = 8'(5 + {$random(seed)} % 20);
		if (kind == 0)
		begin
			rst = 1'b1;
			repeat (10) @(negedge core_clk);
			rst = 1'b0;
		end
		if (kind == 1)
		begin
			reset_n_in = 1'b0;
			repeat (260) @(negedge core_clk);
			reset_n_in = 1'b1;
		end
		{soft_reset, diag_cmd, go} = {kind == 2, kind == 3, 1'b1};
		@(negedge core_clk);
		{soft_reset, diag_cmd, go} = 3'h0;
		if (hard)
			m_present = hp;
		repeat (6) @(negedge core_clk);
		if (m_present || hard)
			check("bsy", bsy, 1'b1);
		n = 0;
		while (!(seq_done === 1'b1 && bsy === 1'b0) && n < 600)
		begin
			@(negedge core_clk);
			n++;
		end
		check("seq_done", seq_done, 1'b1);
		check("slave_present", slave_present, m_present);
		check("slave_pass", slave_pass, m_present & okp);
		$display("master case kind %0d done", kind);
	endtask
	// slave side: cable reset, host command, soft reset, failing diag command
	task automatic scase();
		@(negedge core_clk);
		{rst, is_slave, here, self_done, self_pass} = 5'h19;
		repeat (2) @(negedge core_clk);
		{rst, reset_n_in} = 2'h0;
		repeat (260) @(negedge core_clk);
		reset_n_in = 1'b1;
		repeat (40) @(negedge core_clk);
		check("dasp_n_oe", dasp_n_oe, 1'b0);
		check("pdiag_n_oe", pdiag_n_oe, 1'b1);
		self_done = 1'b1;
		repeat (3) @(negedge core_clk);
		check("pdiag_n_oe", pdiag_n_oe, 1'b0);
		host_cmd = 1'b1;
		@(negedge core_clk);
		{host_cmd, self_done} = 2'h0;
		check("dasp_n_oe", dasp_n_oe, 1'b1);
		soft_reset = 1'b1;
		@(negedge core_clk);
		soft_reset = 1'b0;
		repeat (3) @(negedge core_clk);
		check("dasp_n_oe", dasp_n_oe, 1'b0);
		check("pdiag_n_oe", pdiag_n_oe, 1'b1);
		self_done = 1'b1;
		repeat (10) @(negedge core_clk);
		check("pdiag_n_oe", pdiag_n_oe, 1'b0);
		check("dasp_n_oe", dasp_n_oe, 1'b1);
		{self_done, self_pass, diag_cmd} = 3'h1;
		@(negedge core_clk);
		diag_cmd = 1'b0;
		repeat (3) @(negedge core_clk);
		check("dasp_n_oe", dasp_n_oe, 1'b0);
		self_done = 1'b1;
		repeat (70) @(negedge core_clk);
		check("pdiag_n_oe", pdiag_n_oe, 1'b1);
		check("dasp_n_oe", dasp_n_oe, 1'b1);
		$display("slave case done");
	endtask
	// ********************
	// main sequence
	// ********************
	initial
	begin
		seed = 32'h3ab9dee4;
		mcase(0, 1'b1, 1'b1);
		mcase(2, 1'b1, 1'b1);
		mcase(3, 1'b1, 1'b0);
		mcase(1, 1'b0, 1'b0);
		mcase(2, 1'b1, 1'b1);
		mcase(3, 1'b1, 1'b1);
		mcase(1, 1'b1, 1'b1);
		mcase(3, 1'b1, 1'b1);
		scase();
		finish_test();
	end
endmodule
